// [microcode_load_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "microcode_load_control_consts.svh"

module microcode_load_control
	import microcode_load_control_pkg::*;
#(
	parameter int MEM_WORDS = 65536,
	parameter int STAGE_WORDS = 64
)(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq,
	output logic running,
	output logic [16:0] execAddr
);

	localparam int MW = $clog2(MEM_WORDS);
	localparam int SW = $clog2(STAGE_WORDS);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:0] mem [MEM_WORDS];
	logic [15:0] stage [STAGE_WORDS];

	logic ack_q;
	logic [31:0] dat_q;
	port_state_type state_q;
	engine_type eng_q;
	logic [16:0] addr_q;
	logic [15:0] count_q;
	logic [16:0] start_q;
	logic [3:0] err_q;
	logic [1:0] intStat_q;
	logic [1:0] intEn_q;
	logic [SW-1:0] ptr_q;
	logic [SW-1:0] engIdx_q;
	logic [MW-1:0] memIdx_q;
	logic [15:0] left_q;

	logic req;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic portWr;
	logic funcWr;
	logic dataWr;
	logic dataRd;
	logic [17:0] endAddr;
	logic loadOk;
	logic dumpOk;
	logic sizeOk;
	logic [16:0] wordsRnd;
	logic [15:0] words;
	logic [3:0] funcErr;
	logic cmdDone;
	logic funcDone;
	logic engDone;
	logic errEv;
	logic [1:0] ev;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one request per ack; the ack cycle itself never starts a new one
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr = req & we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};
	assign wdat = dat_i & wmask;
	assign portWr = wr & (adr_i == `OFS_PORT);
	assign funcWr = wr & (adr_i == `OFS_FUNC);
	assign dataWr = wr & (adr_i == `OFS_DATA);
	assign dataRd = req & ~we_i & (adr_i == `OFS_DATA);

	// ----------------------------------------------------------------
	// function checks
	// ----------------------------------------------------------------
	// last byte touched; 18 bits so a wrap past the top is caught
	assign endAddr = {1'b0, addr_q} + {2'b00, count_q} - 18'h00001;
	assign sizeOk = ({1'b0, count_q} <= 17'(2 * STAGE_WORDS));
	assign wordsRnd = ({1'b0, count_q} + 17'h00001) >> 1;
	assign words = wordsRnd[15:0];

	// load window depends on the port state
	always_comb
	begin
		loadOk = 1'b0;
		if (state_q == stHalted)
		begin
			loadOk = ({1'b0, addr_q} >= `WIN_LO)
				& (endAddr <= `WIN_HALT_HI);
		end
		else if (state_q == stReady)
		begin
			loadOk = ({1'b0, addr_q} >= `WIN_LO)
				& (endAddr <= `WIN_READY_HI);
		end
	end

	// dumps may read anywhere inside the memory
	assign dumpOk = (endAddr < 18'(2 * MEM_WORDS));

	// refusal reason for a function write, none when accepted
	always_comb
	begin
		funcErr = `ERR_NONE;
		if (wdat[7:0] == `FUNC_LOAD || wdat[7:0] == `FUNC_DUMP)
		begin
			if (state_q == stRunning || eng_q != engIdle)
				funcErr = `ERR_STATE;
			else if (!sizeOk)
				funcErr = `ERR_SIZE;
			else if (count_q != 16'h0000 && wdat[7:0] == `FUNC_LOAD
				&& !loadOk)
				funcErr = `ERR_WINDOW;
			else if (count_q != 16'h0000 && wdat[7:0] == `FUNC_DUMP
				&& !dumpOk)
				funcErr = `ERR_WINDOW;
		end
		else if (wdat[7:0] == `FUNC_START)
		begin
			if (state_q == stRunning || eng_q != engIdle)
				funcErr = `ERR_STATE;
		end
		else
			funcErr = `ERR_CODE;
	end

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	assign cmdDone = portWr & (wdat[`BIT_RESET]
		| wdat[3:0] == `CMD_HALT | wdat[3:0] == `CMD_STOP);
	// empty blocks and starts finish at once; copies finish in engine
	assign funcDone = funcWr & ((funcErr != `ERR_NONE)
		| wdat[7:0] == `FUNC_START | count_q == 16'h0000);
	assign engDone = (eng_q != engIdle) & (left_q == 16'h0001);
	assign errEv = funcWr & (funcErr != `ERR_NONE);
	assign ev = {errEv, cmdDone | funcDone | engDone};

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	// read data registered with the ack; unmapped offsets read zero
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			dat_q <= 32'h00000000;
		end
		else if (req && !we_i)
		begin
			unique case (adr_i)
				`OFS_PORT: dat_q <= 32'(intStat_q[`INT_DONE]) << `BIT_DONE;
				`OFS_FUNC: dat_q <= 32'h00000000;
				`OFS_ADDR: dat_q <= {15'h0000, addr_q};
				`OFS_COUNT: dat_q <= {16'h0000, count_q};
				`OFS_DATA: dat_q <= {16'h0000, stage[ptr_q]};
				`OFS_STATE: dat_q <= {24'h000000, err_q, eng_q, state_q};
				`OFS_START: dat_q <= {15'h0000, start_q};
				`OFS_INTSTAT: dat_q <= {30'h00000000, intStat_q};
				`OFS_INTEN: dat_q <= {30'h00000000, intEn_q};
				default: dat_q <= 32'h00000000;
			endcase
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ----------------------------------------------------------------
	// host parameter registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			addr_q <= 17'h00000;
			count_q <= 16'h0000;
		end
		else
		begin
			if (wr && adr_i == `OFS_ADDR)
			begin
				addr_q <= (addr_q & ~wmask[16:0]) | wdat[16:0];
			end
			if (wr && adr_i == `OFS_COUNT)
			begin
				count_q <= (count_q & ~wmask[15:0]) | wdat[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// port state
	// ----------------------------------------------------------------
	// reset wins over a command in the same write
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= stReady;
			start_q <= 17'h00000;
		end
		else if (portWr && wdat[`BIT_RESET])
		begin
			state_q <= stReady;
		end
		else if (portWr && wdat[3:0] == `CMD_HALT)
		begin
			state_q <= stHalted;
		end
		else if (portWr && wdat[3:0] == `CMD_STOP)
		begin
			state_q <= stReady;
		end
		else if (funcWr && wdat[7:0] == `FUNC_START
			&& funcErr == `ERR_NONE)
		begin
			state_q <= stRunning;
			start_q <= addr_q;
		end
	end

	assign running = (state_q == stRunning);
	assign execAddr = start_q;

	// last refusal reason, cleared by the next accepted function
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			err_q <= `ERR_NONE;
		else if (portWr && wdat[`BIT_RESET])
			err_q <= `ERR_NONE;
		else if (funcWr)
			err_q <= funcErr;
	end

	// ----------------------------------------------------------------
	// copy engine
	// ----------------------------------------------------------------
	// one word per clock; a port reset abandons a copy midway
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			eng_q <= engIdle;
			engIdx_q <= '0;
			memIdx_q <= '0;
			left_q <= 16'h0000;
		end
		else if (portWr && wdat[`BIT_RESET])
		begin
			eng_q <= engIdle;
			left_q <= 16'h0000;
		end
		else
		begin
			unique case (eng_q)
				engIdle:
				begin
					if (funcWr && funcErr == `ERR_NONE
						&& count_q != 16'h0000)
					begin
						engIdx_q <= '0;
						memIdx_q <= addr_q[MW:1];
						left_q <= words;
						if (wdat[7:0] == `FUNC_LOAD)
						begin
							eng_q <= engLoad;
						end
						else if (wdat[7:0] == `FUNC_DUMP)
						begin
							eng_q <= engDump;
						end
					end
				end
				engLoad, engDump:
				begin
					engIdx_q <= engIdx_q + 1'b1;
					memIdx_q <= memIdx_q + 1'b1;
					left_q <= left_q - 16'h0001;
					if (left_q == 16'h0001)
					begin
						eng_q <= engIdle;
					end
				end
			endcase
		end
	end

	// internal memory takes words only while a checked load runs
	always_ff @(posedge mclk)
	begin
		if (eng_q == engLoad)
			mem[memIdx_q] <= stage[engIdx_q];
	end

	// staging buffer: filled by the host or by a dump
	always_ff @(posedge mclk)
	begin
		if (eng_q == engDump)
			stage[engIdx_q] <= mem[memIdx_q];
		else if (dataWr)
			stage[ptr_q] <= (stage[ptr_q] & ~wmask[15:0]) | wdat[15:0];
	end

	// host window pointer, rewound by every function write
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			ptr_q <= '0;
		else if (funcWr)
			ptr_q <= '0;
		else if (dataWr || dataRd)
			ptr_q <= ptr_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// sticky; a new event beats a clear in the same cycle
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			intStat_q <= 2'b00;
		end
		else
		begin
			intStat_q <= (intStat_q
				& ~((wr && adr_i == `OFS_INTCLR) ? wdat[1:0] : 2'b00)
				& ~{1'b0, portWr & wdat[`BIT_DONE]})
				| ev;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			intEn_q <= 2'b00;
		else if (wr && adr_i == `OFS_INTEN)
			intEn_q <= (intEn_q & ~wmask[1:0]) | wdat[1:0];
	end

	assign irq = |(intStat_q & intEn_q);

endmodule
`default_nettype wire

// [microcode_load_control_consts.svh]
`ifndef MICROCODE_LOAD_CONTROL_CONSTS_SVH
`define MICROCODE_LOAD_CONTROL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_PORT 8'h00
`define OFS_FUNC 8'h04
`define OFS_ADDR 8'h08
`define OFS_COUNT 8'h0c
`define OFS_DATA 8'h10
`define OFS_STATE 8'h14
`define OFS_START 8'h18
`define OFS_INTSTAT 8'h1c
`define OFS_INTCLR 8'h20
`define OFS_INTEN 8'h24

// ----------------------------------------------------------------
// fields, codes and windows
// ----------------------------------------------------------------
`define BIT_RESET 5
`define BIT_DONE 11
`define CMD_NOP 4'h0
`define CMD_HALT 4'h1
`define CMD_STOP 4'h2
`define FUNC_START 8'h01
`define FUNC_DUMP 8'h14
`define FUNC_LOAD 8'h15
`define WIN_LO 18'h04400
`define WIN_HALT_HI 18'h1fffe
`define WIN_READY_HI 18'h06400
`define INT_DONE 0
`define INT_ERR 1
`define ERR_NONE 4'h0
`define ERR_WINDOW 4'h1
`define ERR_STATE 4'h2
`define ERR_SIZE 4'h3
`define ERR_CODE 4'h4

`endif

// [microcode_load_control_pkg.sv]
package microcode_load_control_pkg;
	typedef enum logic [1:0] {
		stReady = 2'b00,
		stHalted = 2'b01,
		stRunning = 2'b11
	} port_state_type;

	typedef enum logic [1:0] {
		engIdle = 2'b00,
		engLoad = 2'b01,
		engDump = 2'b11
	} engine_type;
endpackage

// [microcode_load_control_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "microcode_load_control_consts.svh"
// ----------------------------------------
// bus and control checker
// ----------------------------------------
module microcode_load_control_properties (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq,
	input wire logic running,
	input wire logic [16:0] execAddr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// taken accesses, ack cycle is never a new request
	wire logic wr = cyc_i && stb_i && we_i && !ack_o;
	wire logic rd = cyc_i && stb_i && !we_i && !ack_o;
	wire logic goCmd = wr && adr_i == `OFS_FUNC && dat_i[7:0] == 8'h01;
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_start_runs: assert property (goCmd && sel_i[0] && !running |=> ##[0:2] running)
		else $error("start did not run");
	a_exec_hold: assert property ($changed(execAddr) |-> $past(goCmd))
		else $error("exec address moved without start");
	a_reset_bit: assert property (wr && adr_i == `OFS_PORT && dat_i[5] && sel_i[0] |=> !running)
		else $error("port reset left running");
	a_run_leave: assert property ($fell(running) |-> $past(wr && adr_i == `OFS_PORT))
		else $error("running dropped without port command");
	a_irq_mask: assert property (wr && adr_i == `OFS_INTEN && sel_i[0] && dat_i[1:0] == 2'h0 |=> !irq)
		else $error("masked interrupt still high");
	a_unmapped_zero: assert property (rd && adr_i >= 8'h28 |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// [microcode_load_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "microcode_load_control_consts.svh"
module microcode_load_control_tb_top import microcode_load_control_pkg::*;;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'hf;
	logic [31:0] datO, rdat;
	logic ack, irq, running;
	logic [16:0] execAddr;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int i;
	logic [15:0] pf [8] = '{16'h0008, 16'h8000, 16'h0000, 16'h0000,
		16'hffff, 16'h4400, 16'h0000, 16'h0000};
	microcode_load_control i_microcode_load_control (.mclk(mclk), .reset(reset),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat),
		.sel_i(sel), .dat_o(datO), .ack_o(ack), .irq(irq),
		.running(running), .execAddr(execAddr));
	// ----------------------------------------
	// clock and cycle ceiling
	// ----------------------------------------
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	// whole run needs a few hundred cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			num_errors++;
			end_sim();
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// request held until ack is seen high at a rising edge, then dropped
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		rdat = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			num_errors++;
		end
	endtask
	// clear flags, issue a function, poll done, leave STATE in rdat
	task automatic fn(input logic [31:0] a, input logic [31:0] c, input logic [31:0] f);
		int k;
		k = 0;
		wb(1'b1, `OFS_INTCLR, 32'h3);
		wb(1'b1, `OFS_ADDR, a);
		wb(1'b1, `OFS_COUNT, c);
		wb(1'b1, `OFS_FUNC, f);
		rdat = 32'h0;
		while (rdat[0] !== 1'b1 && k < 400)
		begin
			wb(1'b0, `OFS_INTSTAT, 32'h0);
			k++;
		end
		chk("fndone", 32'h1, {31'h0, rdat[0]});
		wb(1'b0, `OFS_STATE, 32'h0);
	endtask
	// code 0 only rewinds the staging pointer; its error is harmless
	task automatic stage(input logic [15:0] b);
		wb(1'b1, `OFS_FUNC, 32'h0);
		for (int k = 0; k < 4; k++)
			wb(1'b1, `OFS_DATA, {16'h0, b + 16'(k)});
	endtask
	task automatic dumpChk(input logic [31:0] a, input logic [15:0] b);
		fn(a, 32'h8, 32'h14);
		for (int k = 0; k < 4; k++)
		begin
			wb(1'b0, `OFS_DATA, 32'h0);
			chk("dump", {16'h0, b + 16'(k)}, rdat);
		end
	endtask
	task automatic end_sim();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		wb(1'b1, `OFS_PORT, 32'h20);
		wb(1'b0, `OFS_PORT, 32'h0);
		chk("done", 32'h800, rdat);
		wb(1'b1, `OFS_INTEN, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, `OFS_INTCLR, 32'h1);
		chk("irqclr", 32'h0, {31'h0, irq});
		$display("test reset done");
		stage(16'h1000);
		fn(32'h63f8, 32'h8, 32'h15);
		chk("rdyok", 32'h0, rdat);
		wb(1'b1, `OFS_INTEN, 32'h2);
		fn(32'h63fa, 32'h8, 32'h15);
		chk("rdyref", 32'h10, rdat);
		chk("irqerr", 32'h1, {31'h0, irq});
		wb(1'b1, `OFS_INTEN, 32'h0);
		chk("irqmask", 32'h0, {31'h0, irq});
		dumpChk(32'h63f8, 16'h1000);
		$display("test ready window done");
		wb(1'b1, `OFS_INTCLR, 32'h1);
		wb(1'b1, `OFS_PORT, 32'h1);
		wb(1'b0, `OFS_PORT, 32'h0);
		chk("halted", 32'h800, rdat);
		wb(1'b0, `OFS_STATE, 32'h0);
		chk("hstate", 32'h1, {30'h0, rdat[1:0]});
		stage(16'h2000);
		fn(32'h1fff6, 32'h8, 32'h15);
		chk("hiok", 32'h1, rdat);
		stage(16'h3000);
		fn(32'h1fff8, 32'h8, 32'h15);
		chk("hiref", 32'h11, rdat);
		fn(32'h43fe, 32'h8, 32'h15);
		chk("loref", 32'h11, rdat);
		dumpChk(32'h1fff6, 16'h2000);
		$display("test halted window done");
		// patch stream: count and address pairs in four-word blocks
		stage(16'h4000);
		i = 0;
		while (i < 8)
		begin
			if (pf[i] == 16'hffff)
			begin
				wb(1'b1, `OFS_ADDR, {16'h0, pf[i + 1]});
				wb(1'b1, `OFS_FUNC, 32'h1);
				i = 8;
			end
			else if (pf[i] == 16'h0)
				i = (i / 4 + 1) * 4;
			else
			begin
				fn({16'h0, pf[i + 1]}, {16'h0, pf[i]}, 32'h15);
				i = i + 2;
			end
		end
		wb(1'b0, `OFS_STATE, 32'h0);
		chk("run", 32'h3, {30'h0, rdat[1:0]});
		chk("exec", 32'h4400, {15'h0, execAddr});
		fn(32'h5000, 32'h0, 32'h1);
		chk("reref", 32'h2, {28'h0, rdat[7:4]});
		chk("exec2", 32'h4400, {15'h0, execAddr});
		wb(1'b1, `OFS_PORT, 32'h1);
		chk("stopped", 32'h0, {31'h0, running});
		dumpChk(32'h8000, 16'h4000);
		$display("test patch stream done");
		wb(1'b1, `OFS_INTCLR, 32'h1);
		wb(1'b1, `OFS_PORT, 32'h2);
		wb(1'b0, `OFS_PORT, 32'h0);
		chk("stopdone", 32'h800, rdat);
		wb(1'b0, `OFS_STATE, 32'h0);
		chk("stopst", 32'h0, {30'h0, rdat[1:0]});
		fn(32'h4400, 32'h82, 32'h15);
		chk("sizeref", 32'h30, rdat);
		wb(1'b1, `OFS_PORT, 32'h1);
		wb(1'b1, `OFS_INTCLR, 32'h1);
		wb(1'b1, `OFS_PORT, 32'h20);
		wb(1'b0, `OFS_PORT, 32'h0);
		chk("rstdone", 32'h800, rdat);
		wb(1'b0, `OFS_STATE, 32'h0);
		chk("rststate", 32'h0, rdat);
		$display("test stop and port reset done");
		wb(1'b1, 8'h30, 32'hffff);
		wb(1'b0, 8'h30, 32'h0);
		chk("unmapped", 32'h0, rdat);
		$display("test unmapped done");
		end_sim();
	end
endmodule
bind microcode_load_control microcode_load_control_properties i_microcode_load_control_properties (
	.mclk(mclk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
	.irq(irq), .running(running), .execAddr(execAddr));
`default_nettype wire
